// [rtl/spiint_interrupt_logic.sv]
// The strobed register port was chosen for this implementation.
`include "spiint_map.svh"
// What this block does
// - Four enable bits, reset to zero
// - Frame received while receive FIFO full sets overrun
// - Overrun frame overwrites previous frame data
// - Timeout after 32 unread bit periods
// - Receive level flag when half full
// - Transmit level flag when half empty
// - Raw status shows all conditions
// - Gated status is raw AND enable
// - Writing ones to clear register clears
// - Clear bit 0 clears overrun
// - Clear bit 1 clears timeout
// - Level flags follow FIFO, no clear
module spiint_interrupt_logic
	import spiint_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic [3:0] rxLevel,
	input wire logic [3:0] txLevel,
	input wire logic frameReceived,
	input wire logic rxFifoRead,
	input wire logic [7:0] prescaleDivisor,
	input wire logic [7:0] serialClockRate,
	output logic overwriteLast,
	output logic irq
);
	spiint_cond_t enable;
	spiint_cond_t next_enable;
	spiint_cond_t raw;
	spiint_cond_t gated;
	logic overrunRaw;
	logic next_overrunRaw;
	logic timeoutRaw;
	logic next_timeoutRaw;
	logic rxLevelRaw;
	logic next_rxLevelRaw;
	logic txLevelRaw;
	logic next_txLevelRaw;
	logic overwriteHit;
	logic next_overwriteLast;
	logic next_irq;
	logic [31:0] next_regRdata;
	logic [16:0] bitDiv;
	logic [16:0] bitCnt;
	logic [16:0] next_bitCnt;
	logic [5:0] periodCnt;
	logic [5:0] next_periodCnt;
	logic periodsLeft;
	logic bitEnd;
	logic timeoutHit;
	logic countHold;
	logic enableWr;
	logic clearWr;
	logic clearOverrun;
	logic clearTimeout;
	logic readEnable;
	logic readRaw;
	logic readGated;
	logic rxFull;
	logic rxEmpty;
	logic rxHalf;
	logic txHalf;

	// Byte address match for one register
	function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] offset);
		addrHit = (addr == offset);
	endfunction : addrHit

	// Bit period in clock cycles: prescale times (rate plus one)
	function automatic logic [16:0] bitPeriod(input logic [7:0] psc, input logic [7:0] serial_clock_rate);
		bitPeriod = 17'(psc) * (17'(serial_clock_rate) + 17'h00001);
	endfunction : bitPeriod

	// True on the last cycle of a period; a zero limit ends every cycle
	function automatic logic lastCycle(input logic [16:0] cnt, input logic [16:0] limit);
		lastCycle = (cnt + 17'h00001 >= limit);
	endfunction : lastCycle

	// Zero-extend a condition image to a bus word
	function automatic logic [31:0] toWord(input spiint_cond_t cond);
		toWord = {28'h0000000, cond};
	endfunction : toWord

	// Write decode
	assign enableWr = regWr && addrHit(regAddr, `SPIINT_OFF_ENABLE);
	assign clearWr = regWr && addrHit(regAddr, `SPIINT_OFF_CLEAR);
	assign clearOverrun = clearWr && regWdata[`SPIINT_BIT_OVERRUN];
	assign clearTimeout = clearWr && regWdata[`SPIINT_BIT_TIMEOUT];

	// Read decode; the clear register falls through and reads zero
	assign readEnable = regRd && addrHit(regAddr, `SPIINT_OFF_ENABLE);
	assign readRaw = regRd && addrHit(regAddr, `SPIINT_OFF_RAW);
	assign readGated = regRd && addrHit(regAddr, `SPIINT_OFF_GATED);

	// FIFO level decode
	assign rxFull = (rxLevel >= 4'(`SPIINT_FIFO_DEPTH));
	assign rxEmpty = (rxLevel == 4'h0);
	assign rxHalf = (rxLevel >= 4'(`SPIINT_FIFO_DEPTH / 2));
	assign txHalf = (txLevel <= 4'(`SPIINT_FIFO_DEPTH / 2));
	// frame arrives with no room left
	assign overwriteHit = frameReceived && rxFull;

	// Timeout bit-period decode
	assign bitDiv = bitPeriod(prescaleDivisor, serialClockRate);
	assign bitEnd = lastCycle(bitCnt, bitDiv);
	// Count restarts whenever the FIFO is empty or popped
	assign countHold = rxEmpty || rxFifoRead;
	// Counting stops once the full span is reached
	assign periodsLeft = (periodCnt < 6'(`SPIINT_TIMEOUT_BITS));
	// last bit of the final unread period
	assign timeoutHit = !countHold && bitEnd
		&& (periodCnt == 6'(`SPIINT_TIMEOUT_BITS - 1));

	assign raw = {txLevelRaw, rxLevelRaw, timeoutRaw, overrunRaw};
	assign gated = raw & enable;

	// enable register, low four bits only
	always_comb begin
		next_enable = enable;
		if (enableWr) begin
			next_enable = regWdata[3:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			enable <= `SPIINT_ENABLE_RST;
		end else if (clkEn) begin
			enable <= next_enable;
		end
	end

	// overrun set; a frame into a full receive FIFO beats a clear in the same cycle
	always_comb begin
		next_overrunRaw = overrunRaw;
		if (overwriteHit) begin
			next_overrunRaw = 1'h1;
		end else if (clearOverrun) begin
			next_overrunRaw = 1'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			overrunRaw <= `SPIINT_OVERRUN_RST;
		end else if (clkEn) begin
			overrunRaw <= next_overrunRaw;
		end
	end

	// FIFO overwrites its newest entry on overrun
	always_comb begin
		next_overwriteLast = overwriteHit;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			overwriteLast <= `SPIINT_OVERWRITE_RST;
		end else if (clkEn) begin
			overwriteLast <= next_overwriteLast;
		end
	end

	always_comb begin
		next_bitCnt = bitCnt;
		if (countHold) begin
			next_bitCnt = 17'h00000;
		end else if (periodsLeft) begin
			if (bitEnd) begin
				next_bitCnt = 17'h00000;
			end else begin
				next_bitCnt = bitCnt + 17'h00001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bitCnt <= 17'h00000;
		end else if (clkEn) begin
			bitCnt <= next_bitCnt;
		end
	end

	// unread bit periods, held at the limit
	always_comb begin
		next_periodCnt = periodCnt;
		if (countHold) begin
			next_periodCnt = 6'h00;
		end else if (periodsLeft && bitEnd) begin
			next_periodCnt = periodCnt + 6'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			periodCnt <= 6'h00;
		end else if (clkEn) begin
			periodCnt <= next_periodCnt;
		end
	end

	// timeout flag; the set beats a clear in the same cycle
	always_comb begin
		next_timeoutRaw = timeoutRaw;
		if (timeoutHit) begin
			next_timeoutRaw = 1'h1;
		end else if (clearTimeout) begin
			next_timeoutRaw = 1'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			timeoutRaw <= `SPIINT_TIMEOUT_RST;
		end else if (clkEn) begin
			timeoutRaw <= next_timeoutRaw;
		end
	end

	// receive level flag follows the FIFO only
	always_comb begin
		next_rxLevelRaw = rxHalf;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rxLevelRaw <= `SPIINT_RXLEVEL_RST;
		end else if (clkEn) begin
			rxLevelRaw <= next_rxLevelRaw;
		end
	end

	// transmit level flag follows the FIFO only
	always_comb begin
		next_txLevelRaw = txHalf;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			txLevelRaw <= `SPIINT_TXLEVEL_RST;
		end else if (clkEn) begin
			txLevelRaw <= next_txLevelRaw;
		end
	end

	// single request line, one cycle behind the gated image
	always_comb begin
		next_irq = |gated;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			irq <= `SPIINT_IRQ_RST;
		end else if (clkEn) begin
			irq <= next_irq;
		end
	end

	// read data stand one cycle, reserved bits zero
	always_comb begin
		next_regRdata = `SPIINT_RDATA_RST;
		if (readEnable) begin
			next_regRdata = toWord(enable);
		end else if (readRaw) begin
			next_regRdata = toWord(raw);
		end else if (readGated) begin
			next_regRdata = toWord(gated);
		end
	end

	// Idle cycles with clkEn high return zero; while clkEn is low the last read data holds on the bus
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			regRdata <= `SPIINT_RDATA_RST;
		end else if (clkEn) begin
			regRdata <= next_regRdata;
		end
	end
endmodule : spiint_interrupt_logic

// [rtl/spiint_map.svh]
`ifndef SPIINT_MAP_SVH
`define SPIINT_MAP_SVH
`define SPIINT_ADDR_W 8
`define SPIINT_OFF_ENABLE 8'h14
`define SPIINT_OFF_RAW 8'h18
`define SPIINT_OFF_GATED 8'h1C
`define SPIINT_OFF_CLEAR 8'h20
`define SPIINT_BIT_OVERRUN 0
`define SPIINT_BIT_TIMEOUT 1
`define SPIINT_BIT_RXLEVEL 2
`define SPIINT_BIT_TXLEVEL 3
`define SPIINT_ENABLE_RST 4'h0
`define SPIINT_OVERRUN_RST 1'h0
`define SPIINT_TIMEOUT_RST 1'h0
`define SPIINT_RXLEVEL_RST 1'h0
`define SPIINT_TXLEVEL_RST 1'h1
`define SPIINT_IRQ_RST 1'h0
`define SPIINT_OVERWRITE_RST 1'h0
`define SPIINT_RDATA_RST 32'h00000000
`define SPIINT_TIMEOUT_BITS 32
`define SPIINT_FIFO_DEPTH 8
`define SPIINT_LEVEL_W 4
`endif

// [rtl/spiint_pkg.sv]
package spiint_pkg;
	typedef logic [3:0] spiint_cond_t;
	typedef logic [7:0] spiint_addr_t;
endpackage : spiint_pkg

// [tb/spiint_chk.sv]
module spiint_chk (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic [3:0] rxLevel,
	input wire logic frameReceived,
	input wire logic overwriteLast,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	sequence enWrite;
		clkEn && regWr && regAddr == 8'h14;
	endsequence
	sequence enRead;
		clkEn && regRd && regAddr == 8'h14;
	endsequence
	sequence ovrClear;
		clkEn && regWr && regAddr == 8'h20 && regWdata[0] && !(frameReceived && rxLevel >= 4'h8);
	endsequence
	sequence rawRead;
		clkEn && regRd && regAddr == 8'h18;
	endsequence
	resv_a: assert property (regRd |=> regRdata[31:4] == 28'h0) else $error("resv set");
	unmap_a: assert property (clkEn && regRd && regAddr == 8'h40 |=> !regRdata)
		else $error("unmap");
	irq_or_a: assert property (clkEn && regRd && regAddr == 8'h1C |=> irq == |regRdata)
		else $error("irq not or");
	rdata_idle_a: assert property (clkEn && !regRd |=> regRdata == 32'h0)
		else $error("read data not idle");
	en_back_a: assert property (enWrite ##1 (clkEn && !regWr) ##1 enRead
		|=> regRdata[3:0] == $past(regWdata[3:0], 3)) else $error("enable readback");
	ovr_clear_a: assert property (ovrClear ##1 (clkEn && !frameReceived) ##1 rawRead
		|=> !regRdata[0]) else $error("overrun not cleared");
	overwrite_a: assert property (clkEn && frameReceived && rxLevel >= 4'h8 |=> overwriteLast)
		else $error("no overwrite pulse");
	freeze_a: assert property (!clkEn |=> $stable(regRdata) && $stable(irq))
		else $error("not frozen");
endmodule : spiint_chk

// [tb/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'h0, rstn = 1'h0, clkEn = 1'h1, regWr = 1'h0, regRd = 1'h0;
	logic irq, overwriteLast;
	logic frameReceived = 1'h0, rxFifoRead = 1'h0;
	logic [7:0] regAddr = 8'h00, prescaleDivisor = 8'hFE, serialClockRate = 8'hFF;
	logic [31:0] regWdata = 32'h0, regRdata;
	logic [3:0] rxLevel = 4'h0, txLevel = 4'h0;
	logic [11:0] rows [4] = '{12'h008, 12'h454, 12'h348, 12'h884};
	int n_mismatch = 0, compares = 0;
	spiint_interrupt_logic i_dut(.*);
	always #12.5 clk_sys = ~clk_sys;
	task check_word(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value rdata at %h exp %h got %h", a, exp, got);
		end
	endtask : check_word
	task check_bit(input string name, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s exp %b got %b", name, exp, got);
		end
	endtask : check_bit
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{regWr, regRd, regAddr, regWdata} <= {w, !w, a, d};
		@(posedge clk_sys);
		{regWr, regRd} <= 2'h0;
		#1;
		if (!w) begin
			check_word(a, d, regRdata);
		end
	endtask : bus
	task give_verdict;
		$display("cmp %0d bad %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	initial begin
		#100us;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'h1;
		bus(1'h0, 8'h14, 32'h0);
		foreach (rows[i]) begin
			@(posedge clk_sys) {rxLevel, txLevel} <= rows[i][11:4];
			bus(1'h0, 8'h18, {28'h0, rows[i][3:0]});
			$display("row %0d done", i);
		end
		bus(1'h1, 8'h14, 32'hF);
		bus(1'h0, 8'h14, 32'hF);
		@(posedge clk_sys) frameReceived <= 1'h1;
		@(posedge clk_sys) frameReceived <= 1'h0;
		#1 check_bit("overwriteLast", 1'h1, overwriteLast);
		bus(1'h0, 8'h1C, 32'h5);
		#1 check_bit("irq", 1'h1, irq);
		bus(1'h1, 8'h20, 32'h1);
		bus(1'h0, 8'h18, 32'h4);
		$display("overrun test done");
		bus(1'h1, 8'h14, 32'h2);
		@(posedge clk_sys) {prescaleDivisor, serialClockRate, rxFifoRead} <= {8'h02, 8'h00, 1'h1};
		@(posedge clk_sys) rxFifoRead <= 1'h0;
		repeat (64) @(posedge clk_sys);
		#1 check_bit("irq", 1'h0, irq);
		@(posedge clk_sys);
		#1 check_bit("irq", 1'h1, irq);
		bus(1'h0, 8'h18, 32'h6);
		@(posedge clk_sys) rxFifoRead <= 1'h1;
		bus(1'h1, 8'h20, 32'h2);
		bus(1'h0, 8'h18, 32'h4);
		$display("timeout test done");
		@(posedge clk_sys) {frameReceived, regWr, regAddr, regWdata} <= {1'h1, 1'h1, 8'h20, 32'h1};
		@(posedge clk_sys) {frameReceived, regWr} <= 2'h0;
		bus(1'h1, 8'h20, 32'h0);
		bus(1'h0, 8'h18, 32'h5);
		bus(1'h1, 8'h14, 32'h0);
		bus(1'h0, 8'h1C, 32'h0);
		#1 check_bit("irq", 1'h0, irq);
		bus(1'h0, 8'h40, 32'h0);
		bus(1'h0, 8'h20, 32'h0);
		$display("set wins test done");
		@(posedge clk_sys) clkEn <= 1'h0;
		bus(1'h1, 8'h14, 32'hF);
		@(posedge clk_sys) clkEn <= 1'h1;
		bus(1'h0, 8'h14, 32'h0);
		$display("freeze test done");
		bus(1'h1, 8'h14, 32'hF);
		@(posedge clk_sys) rstn <= 1'h0;
		repeat (2) @(posedge clk_sys);
		#1 check_bit("irq", 1'h0, irq);
		check_bit("overwriteLast", 1'h0, overwriteLast);
		@(posedge clk_sys) rstn <= 1'h1;
		bus(1'h0, 8'h14, 32'h0);
		bus(1'h0, 8'h18, 32'h4);
		$display("reset test done");
		give_verdict;
	end
endmodule : tb
bind spiint_interrupt_logic spiint_chk i_chk(
	.clk_sys(clk_sys),
	.rstn(rstn),
	.clkEn(clkEn),
	.regAddr(regAddr),
	.regWdata(regWdata),
	.regWr(regWr),
	.regRd(regRd),
	.regRdata(regRdata),
	.rxLevel(rxLevel),
	.frameReceived(frameReceived),
	.overwriteLast(overwriteLast),
	.irq(irq)
);
